// ---- core/smfc_defines.svh ----
`ifndef SMFC_DEFINES_SVH
`define SMFC_DEFINES_SVH

// clock and watchdog timing
`define SMFC_CLK_NS       40
`define SMFC_CLK_KHZ      25000
`define SMFC_WD_TIME_MS   100
`define SMFC_WD_W         22
// each start-up step after the self test lasts this long; the self test lasts one cycle less
`define SMFC_STEP_TIME_NS 640
`define SMFC_STEP_CYC     ((`SMFC_STEP_TIME_NS + `SMFC_CLK_NS - 1) / `SMFC_CLK_NS)
`define SMFC_STEP_W       5

// link opcode layout, first byte of a frame, msb first
`define SMFC_OP_W         8
`define SMFC_BIT_W        4
`define SMFC_OP_POSITION  8'h13
`define SMFC_OP_RESTART   8'h2F

// gain loop: 47% and 63.5% of a 2^15 span
`define SMFC_GAIN_W       8
`define SMFC_FIELD_W      16
`define SMFC_NORM_LO      16'h3C29
`define SMFC_NORM_HI      16'h5147

`define SMFC_INIT_W       4
`define SMFC_BG_W         3
`define SMFC_EXC_W        4

`endif

// ---- core/smfc_mode_ctrl.sv ----
// Operation
// - watchdog reset acts as power-on reset; first reply afterwards is ready
// - an empty reply caused by protection error is followed by an error reply
// - start-up runs self tests, gain adjust, temperature, first diagnostics
// - diagnostics keep running throughout normal operation
// - serial link stays disabled until start-up ends; enabling is last
// - digital error enters fail-safe, blocking position calculation and position replies
// - fail-safe holds analog off and stops diagnostics and background tasks
// - fail-safe waits for the master to request a reset
// - fail-safe leaves watchdog unserviced so it resets after 100 ms
// - fail-safe keeps only the link; restart is the only command obeyed
// - fail-safe answers every command except restart with the link-error reply
// - init failure of ram, watchdog, rom or eeprom test enters fail-safe
// - background ram, rom or eeprom check failure enters fail-safe
// - system exceptions and firmware flow errors enter fail-safe
// - gain code is recomputed once per position request
// - new gain code derives from field magnitude over x, y, z
// - gain loop keeps magnitude within 47%..63.5%, code within floor..ceiling
// - diagnostic failures are reported via the two error flags
// - equal floor and ceiling hold the gain code fixed
`timescale 1ns/1ns
`include "smfc_defines.svh"

module smfc_mode_ctrl
  import smfc_pkg::*;
#(
  parameter int WD_CYCLES = `SMFC_WD_TIME_MS * `SMFC_CLK_KHZ
) (
  input  wire logic                     MCLK_I,
  input  wire logic                     NRST_I,
  input  wire logic                     SCLK_I,
  input  wire logic                     SS_N_I,
  input  wire logic                     MOSI_I,
  input  wire logic [`SMFC_INIT_W-1:0]  INIT_FAIL_I,
  input  wire logic [`SMFC_BG_W-1:0]    BG_FAIL_I,
  input  wire logic [`SMFC_EXC_W-1:0]   EXC_I,
  input  wire logic                     FLOW_ERR_I,
  input  wire logic                     PROT_ERR_I,
  input  wire logic                     WD_KICK_I,
  input  wire logic [1:0]               DIAG_REPORT_I,
  input  wire logic [`SMFC_FIELD_W-1:0] FIELD_X_I,
  input  wire logic [`SMFC_FIELD_W-1:0] FIELD_Y_I,
  input  wire logic [`SMFC_FIELD_W-1:0] FIELD_Z_I,
  input  wire logic [`SMFC_GAIN_W-1:0]  GAIN_FLOOR_I,
  input  wire logic [`SMFC_GAIN_W-1:0]  GAIN_CEIL_I,
  output logic                          BIST_RUN_O,
  output logic                          GAIN_ADJ_O,
  output logic                          TEMP_ACQ_O,
  output logic                          DIAG_RUN_O,
  output logic                          BG_RUN_O,
  output logic                          ANALOG_ON_O,
  output logic                          LINK_EN_O,
  output logic                          POS_EN_O,
  output logic                          FAILSAFE_O,
  output logic [`SMFC_GAIN_W-1:0]       GAIN_CODE_O,
  output logic                          REPLY_VALID_O,
  output smfc_reply_type                REPLY_KIND_O,
  output logic                          ERR_FLAG_LOW_O,
  output logic                          ERR_FLAG_HIGH_O
);

  localparam logic [`SMFC_STEP_W-1:0] STEP_LAST = `SMFC_STEP_W'(`SMFC_STEP_CYC - 1);
  localparam logic [`SMFC_WD_W-1:0]   WD_LAST   = `SMFC_WD_W'(WD_CYCLES - 1);

  smfc_state_type              s;
  smfc_state_type              next_s;
  logic                        sclk_rise;
  logic                        frame_end;
  logic                        step_end;
  logic                        wd_expire;
  logic                        any_exc;
  logic                        bg_fail;
  logic                        is_restart;
  logic [`SMFC_FIELD_W-1:0]    ax;
  logic [`SMFC_FIELD_W-1:0]    ay;
  logic [`SMFC_FIELD_W-1:0]    az;
  logic [`SMFC_FIELD_W-1:0]    norm;
  logic [`SMFC_GAIN_W-1:0]     gain_new;

  ////////////////////////////////////////////////////////////////////////////
  // decoded levels

  // edge history resets to zero, so gating with the link hides the false edge
  assign sclk_rise  = LINK_EN_O & s.sync2.sclk & ~s.prev.sclk;
  assign frame_end  = LINK_EN_O & s.sync2.ss_n & ~s.prev.ss_n;
  assign step_end   = (s.step_cnt == STEP_LAST);
  assign wd_expire  = (s.wd_cnt == WD_LAST);
  assign any_exc    = (|EXC_I) | FLOW_ERR_I;
  assign bg_fail    = |BG_FAIL_I;
  assign is_restart = (s.opcode == `SMFC_OP_RESTART);

  assign BIST_RUN_O  = (s.st == ST_BIST);
  assign GAIN_ADJ_O  = (s.st == ST_GAIN);
  assign TEMP_ACQ_O  = (s.st == ST_TEMP);
  assign DIAG_RUN_O  = (s.st == ST_DIAG) || (s.st == ST_RUN);
  assign BG_RUN_O    = (s.st == ST_RUN);
  assign ANALOG_ON_O = (s.st != ST_FAIL) && (s.st != ST_RESET);
  assign LINK_EN_O   = (s.st == ST_RUN) || (s.st == ST_FAIL);
  assign POS_EN_O    = (s.st == ST_RUN);
  assign FAILSAFE_O  = (s.st == ST_FAIL);

  assign GAIN_CODE_O     = s.gain;
  assign REPLY_VALID_O   = s.reply_valid;
  assign REPLY_KIND_O    = s.reply_kind;
  assign ERR_FLAG_LOW_O  = s.err_lo;
  assign ERR_FLAG_HIGH_O = s.err_hi;

  ////////////////////////////////////////////////////////////////////////////
  // gain loop

  // magnitude is the largest absolute component
  always_comb begin
    ax   = FIELD_X_I[`SMFC_FIELD_W-1] ? `SMFC_FIELD_W'(-FIELD_X_I) : FIELD_X_I;
    ay   = FIELD_Y_I[`SMFC_FIELD_W-1] ? `SMFC_FIELD_W'(-FIELD_Y_I) : FIELD_Y_I;
    az   = FIELD_Z_I[`SMFC_FIELD_W-1] ? `SMFC_FIELD_W'(-FIELD_Z_I) : FIELD_Z_I;
    norm = (ax > ay) ? ax : ay;
    if (az > norm) begin
      norm = az;
    end
  end

  // one step per call keeps the loop slew-limited, trading tracking speed for stability
  always_comb begin
    gain_new = s.gain;
    if (norm < `SMFC_NORM_LO && s.gain < GAIN_CEIL_I) begin
      gain_new = s.gain + `SMFC_GAIN_W'(1);
    end else if (norm > `SMFC_NORM_HI && s.gain > GAIN_FLOOR_I) begin
      gain_new = s.gain - `SMFC_GAIN_W'(1);
    end
    if (gain_new < GAIN_FLOOR_I) begin
      gain_new = GAIN_FLOOR_I;
    end
    if (gain_new > GAIN_CEIL_I) begin
      gain_new = GAIN_CEIL_I;
    end
    if (GAIN_FLOOR_I == GAIN_CEIL_I) begin
      gain_new = GAIN_FLOOR_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s             = s;
    next_s.reply_valid = 1'b0;
    next_s.sync1       = '{sclk: SCLK_I, ss_n: SS_N_I, mosi: MOSI_I};
    next_s.sync2       = s.sync1;
    next_s.prev        = s.sync2;

    // opcode capture, ignored while the link is off
    if (LINK_EN_O && !s.sync2.ss_n && sclk_rise && s.bit_cnt < `SMFC_BIT_W'(`SMFC_OP_W)) begin
      next_s.opcode  = {s.opcode[`SMFC_OP_W-2:0], s.sync2.mosi};
      next_s.bit_cnt = s.bit_cnt + `SMFC_BIT_W'(1);
    end
    if (frame_end) begin
      next_s.bit_cnt = '0;
    end

    if (s.st != ST_RUN && s.st != ST_FAIL) begin
      next_s.step_cnt = step_end ? '0 : s.step_cnt + `SMFC_STEP_W'(1);
    end

    // fail-safe never services the watchdog
    // counted before the case so that a restart clears it like a reset
    next_s.wd_cnt = (WD_KICK_I && s.st != ST_FAIL) ? '0 : s.wd_cnt + `SMFC_WD_W'(1);

    case (s.st)
      ST_RESET: begin
        next_s.st = ST_BIST;
      end
      ST_BIST: begin
        if (step_end) begin
          next_s.st = (|INIT_FAIL_I) ? ST_FAIL : ST_GAIN;
        end
      end
      ST_GAIN: begin
        next_s.gain = gain_new;
        if (step_end) begin
          next_s.st = ST_TEMP;
        end
      end
      ST_TEMP: begin
        if (step_end) begin
          next_s.st = ST_DIAG;
        end
      end
      ST_DIAG: begin
        if (step_end) begin
          next_s.st = ST_LINK;
        end
      end
      ST_LINK: begin
        if (step_end) begin
          next_s.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (PROT_ERR_I) begin
          next_s.prot_pend = 1'b1;
        end
        if (frame_end) begin
          next_s.reply_valid = 1'b1;
          if (!s.ready_sent) begin
            next_s.reply_kind = RP_READY;
            next_s.ready_sent = 1'b1;
          end else if (s.prot_pend) begin
            next_s.reply_kind = RP_EMPTY;
            next_s.prot_pend  = PROT_ERR_I;
            next_s.err_follow = 1'b1;
          end else if (s.err_follow) begin
            next_s.reply_kind = RP_ERROR;
            next_s.err_follow = 1'b0;
          end else if (s.opcode == `SMFC_OP_POSITION) begin
            next_s.reply_kind = RP_POSITION;
            next_s.gain       = gain_new;
            next_s.err_lo     = DIAG_REPORT_I[0];
            next_s.err_hi     = DIAG_REPORT_I[1];
          end else begin
            next_s.reply_kind = RP_OTHER;
          end
          if (is_restart) begin
            next_s = '0;
          end
        end
      end
      ST_FAIL: begin
        // link-error to all but restart, the only command obeyed
        if (frame_end) begin
          next_s.reply_valid = 1'b1;
          next_s.reply_kind  = RP_LINK_ERR;
          if (is_restart) begin
            next_s = '0;
          end
        end
      end
      default: begin
        next_s.st = ST_RESET;
      end
    endcase

    if (s.st != ST_FAIL && s.st != ST_RESET && any_exc) begin
      next_s.st = ST_FAIL;
    end
    if (DIAG_RUN_O && bg_fail) begin
      next_s.st = ST_FAIL;
    end

    if (wd_expire) begin
      next_s = '0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);

  a_fs_analog_off: assert property (
    FAILSAFE_O |-> !ANALOG_ON_O && !DIAG_RUN_O && !BG_RUN_O)
    else $error("fail-safe left analog or diagnostics running");
  a_fs_no_pos: assert property (
    FAILSAFE_O |-> !POS_EN_O && !(REPLY_VALID_O && REPLY_KIND_O == RP_POSITION))
    else $error("position active in fail-safe");
  a_link_gate: assert property (s.st != ST_RUN && s.st != ST_FAIL |-> !LINK_EN_O)
    else $error("link enabled during start-up");
  a_init_fail: assert property (
    BIST_RUN_O && step_end && |INIT_FAIL_I && !wd_expire |=> FAILSAFE_O)
    else $error("init failure missed");
  a_bg_fail: assert property (DIAG_RUN_O && bg_fail && !wd_expire |=> FAILSAFE_O)
    else $error("background failure missed");
  a_exc_fail: assert property (POS_EN_O && any_exc && !wd_expire |=> FAILSAFE_O)
    else $error("exception missed");
  a_fs_stay: assert property (
    FAILSAFE_O && !wd_expire && !(frame_end && is_restart) |=> FAILSAFE_O)
    else $error("fail-safe left without reset");
  // the restart frame resets instead of replying
  a_fs_reply: assert property (
    FAILSAFE_O && frame_end && !is_restart && !wd_expire
    |=> REPLY_VALID_O && REPLY_KIND_O == RP_LINK_ERR)
    else $error("fail-safe reply not link-error");
  a_first_ready: assert property (
    REPLY_VALID_O && !$past(s.ready_sent) && !$past(FAILSAFE_O)
    |-> REPLY_KIND_O == RP_READY)
    else $error("first reply after reset not ready");
  a_empty_err: assert property (
    POS_EN_O && frame_end && s.err_follow && !s.prot_pend && !is_restart && !wd_expire
    |=> REPLY_VALID_O && REPLY_KIND_O == RP_ERROR)
    else $error("empty reply not followed by error reply");
  a_gain_fixed: assert property (
    POS_EN_O && frame_end && GAIN_FLOOR_I == GAIN_CEIL_I && !is_restart && !wd_expire
    |=> GAIN_CODE_O == $past(GAIN_FLOOR_I))
    else $error("fixed gain not held");
  a_wd_reset: assert property (
    FAILSAFE_O && wd_expire |=> s.st == ST_RESET ##1 BIST_RUN_O)
    else $error("watchdog did not reset fail-safe");

endmodule : smfc_mode_ctrl

// ---- core/smfc_pkg.sv ----
`include "smfc_defines.svh"

package smfc_pkg;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_BIST  = 3'h1,
    ST_GAIN  = 3'h2,
    ST_TEMP  = 3'h3,
    ST_DIAG  = 3'h4,
    ST_LINK  = 3'h5,
    ST_RUN   = 3'h6,
    ST_FAIL  = 3'h7
  } smfc_st_type;

  typedef enum logic [2:0] {
    RP_READY    = 3'h0,
    RP_POSITION = 3'h1,
    RP_EMPTY    = 3'h2,
    RP_ERROR    = 3'h3,
    RP_LINK_ERR = 3'h4,
    RP_OTHER    = 3'h5
  } smfc_reply_type;

  typedef struct packed {
    logic sclk;
    logic ss_n;
    logic mosi;
  } smfc_link_type;

  typedef struct packed {
    smfc_st_type              st;
    logic [`SMFC_STEP_W-1:0]  step_cnt;
    logic [`SMFC_WD_W-1:0]    wd_cnt;
    logic [`SMFC_GAIN_W-1:0]  gain;
    smfc_link_type            sync1;
    smfc_link_type            sync2;
    smfc_link_type            prev;
    logic [`SMFC_BIT_W-1:0]   bit_cnt;
    logic [`SMFC_OP_W-1:0]    opcode;
    logic                     ready_sent;
    logic                     prot_pend;
    logic                     err_follow;
    logic                     reply_valid;
    smfc_reply_type           reply_kind;
    logic                     err_lo;
    logic                     err_hi;
  } smfc_state_type;

endpackage : smfc_pkg

// ---- verif/smfc_master_model.sv ----
`timescale 1ns/1ns
`include "smfc_defines.svh"

module smfc_master_model
  import smfc_pkg::*;
(
  output smfc_link_type link_o,
  output logic          unreliable_o
);
  int      blind_left;
  realtime last_end;

  initial begin
    link_o       = '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b1};
    unreliable_o = 1'b1;
    blind_left   = 6;
    last_end     = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one frame, msb first; the clock stands low between frames
  task automatic send(input logic [`SMFC_OP_W-1:0] op);
    if ($realtime - last_end > 20000) blind_left = 6;
    unreliable_o = (blind_left != 0);
    if (blind_left != 0) blind_left--;
    #13 link_o.ss_n = 1'b0;
    for (int i = `SMFC_OP_W - 1; i >= 0; i--) begin
      link_o.mosi = op[i];
      #160 link_o.sclk = 1'b1;
      #160 link_o.sclk = 1'b0;
    end
    #160 link_o.ss_n = 1'b1;
    // inverted after release, so a stale bit cannot pass for data
    link_o.mosi = ~link_o.mosi;
    last_end = $realtime;
  endtask : send
endmodule : smfc_master_model

// ---- verif/smfc_mode_ctrl_tb_top.sv ----
`timescale 1ns/1ns
`include "smfc_defines.svh"

module smfc_mode_ctrl_tb_top
  import smfc_pkg::*;
;
  // short watchdog keeps the fail-safe exits quick
  localparam int WD = 400;
  localparam logic [7:0] POS = `SMFC_OP_POSITION;

  logic                     mclk, nrst_n, flow_err, prot_err;
  logic [`SMFC_INIT_W-1:0]  init_fail;
  logic [`SMFC_BG_W-1:0]    bg_fail;
  logic [`SMFC_EXC_W-1:0]   exc;
  logic [1:0]               diag_rep;
  logic [`SMFC_FIELD_W-1:0] fx, fy, fz;
  logic [`SMFC_GAIN_W-1:0]  gfloor, gceil, gain, exp_gain;
  logic                     bist, gadj, tacq, diag, bg, ana, link_en, pos_en, fs;
  logic                     rvalid, elo, ehi, unrel, kick;
  smfc_reply_type           rkind;
  smfc_link_type            lnk;
  int                       fail_count, total_checks, cnt;

  smfc_master_model mst (.link_o(lnk), .unreliable_o(unrel));

  smfc_mode_ctrl #(.WD_CYCLES(WD)) dut (
    .MCLK_I(mclk), .NRST_I(nrst_n), .SCLK_I(lnk.sclk), .SS_N_I(lnk.ss_n),
    .MOSI_I(lnk.mosi), .INIT_FAIL_I(init_fail), .BG_FAIL_I(bg_fail), .EXC_I(exc),
    .FLOW_ERR_I(flow_err), .PROT_ERR_I(prot_err), .WD_KICK_I(kick),
    .DIAG_REPORT_I(diag_rep), .FIELD_X_I(fx), .FIELD_Y_I(fy), .FIELD_Z_I(fz),
    .GAIN_FLOOR_I(gfloor), .GAIN_CEIL_I(gceil), .BIST_RUN_O(bist), .GAIN_ADJ_O(gadj),
    .TEMP_ACQ_O(tacq), .DIAG_RUN_O(diag), .BG_RUN_O(bg), .ANALOG_ON_O(ana),
    .LINK_EN_O(link_en), .POS_EN_O(pos_en), .FAILSAFE_O(fs), .GAIN_CODE_O(gain),
    .REPLY_VALID_O(rvalid), .REPLY_KIND_O(rkind), .ERR_FLAG_LOW_O(elo),
    .ERR_FLAG_HIGH_O(ehi)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : step

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // one frame, then a bounded wait for the one-cycle reply pulse
  task automatic ask(input logic [7:0] op, input smfc_reply_type exp);
    logic got;
    mst.send(op);
    got = 1'b0;
    for (int i = 0; i < 24 && !got; i++) begin
      step(1);
      got = (rvalid === 1'b1);
    end
    check("reply pulse", got, 1'b1);
    check("reply kind", rkind, exp);
  endtask : ask

  task automatic wait_run();
    for (int i = 0; i < 300 && pos_en !== 1'b1; i++) step(1);
  endtask : wait_run

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst_n, flow_err, prot_err, init_fail, bg_fail, exc, diag_rep} = '0;
    kick = 1'b1;
    fx = 16'h4000;
    fy = 16'h0100;
    fz = 16'hFF00;
    gfloor = 8'h10;
    gceil = 8'h12;
    step(4);
    check("idle outputs", {bist, gadj, tacq, diag, bg, ana, link_en, pos_en, fs, rvalid}, 0);
    nrst_n = 1'b1;
    step(9);
    for (int k = 0; k < 5; k++) begin
      // the link stays off through the last step and rises with normal run
      check("start-up step", {bist, gadj, tacq, diag, link_en},
            (k < 4) ? (5'b10000 >> k) : 5'b00000);
      step(16);
    end
    check("run outputs", {link_en, pos_en, diag, bg, ana}, 5'b11111);
    ask(POS, RP_READY);
    ask(8'h55, RP_OTHER);
    check("gain after other", gain, 8'h10);
    exp_gain = 8'h10;
    // a negative component counts by its magnitude
    for (int i = 0; i < 6; i++) begin
      fx = (i < 3) ? 16'hF000 : 16'h0800;
      fy = (i < 3) ? 16'h0100 : 16'h6000;
      exp_gain = (i < 3) ? ((exp_gain < gceil) ? exp_gain + 1 : gceil)
                         : ((exp_gain > gfloor) ? exp_gain - 1 : gfloor);
      ask(POS, RP_POSITION);
      check("gain code", gain, exp_gain);
    end
    gfloor = 8'h30;
    gceil = 8'h30;
    ask(POS, RP_POSITION);
    check("fixed gain", gain, 8'h30);
    for (int i = 0; i < 4; i++) begin
      diag_rep = i[1:0];
      ask(POS, RP_POSITION);
      if (unrel !== 1'b1) check("error flags", {ehi, elo}, i[1:0]);
    end
    diag_rep = 2'b00;
    prot_err = 1'b1;
    step(1);
    prot_err = 1'b0;
    ask(POS, RP_EMPTY);
    ask(POS, RP_ERROR);
    ask(POS, RP_POSITION);
    // every fault source in turn; exits alternate restart and watchdog
    for (int f = 0; f < 12; f++) begin
      {flow_err, exc, bg_fail, init_fail} = 12'h001 << f;
      if (f < 4) begin
        nrst_n = 1'b0;
        step(2);
        nrst_n = 1'b1;
        step(40);
      end else begin
        step(2);
      end
      check("safe state", {fs, pos_en, link_en}, 3'b101);
      check("safe analog", {ana, diag, bg}, 3'b000);
      {flow_err, exc, bg_fail, init_fail} = '0;
      ask(POS, RP_LINK_ERR);
      check("safe after command", fs, 1'b1);
      if (f[0]) begin
        cnt = 0;
        while (fs === 1'b1 && cnt < WD + 50) begin
          step(1);
          cnt++;
        end
        check("watchdog exit", fs, 1'b0);
        check("watchdog span", cnt > WD - 120, 1'b1);
      end else begin
        mst.send(`SMFC_OP_RESTART);
      end
      wait_run();
      ask(POS, RP_READY);
    end
    // an unserviced watchdog in normal run acts as a power-on reset
    kick = 1'b0;
    cnt = 0;
    while (bist !== 1'b1 && cnt < WD + 50) begin
      step(1);
      cnt++;
    end
    kick = 1'b1;
    check("watchdog restart", bist, 1'b1);
    check("watchdog restart span", cnt > WD - 120, 1'b1);
    wait_run();
    ask(POS, RP_READY);
    stop_test();
  end

  // the whole sequence needs well under a millisecond
  initial begin
    #3_000_000;
    fail_count++;
    stop_test();
  end
endmodule : smfc_mode_ctrl_tb_top
